// *** rtl/xfc_defines.svh ***
/*
  Offsets, field positions, reset values and fixed addresses of the
  descriptor transfer controller. Included by its bare name.
*/
`ifndef XFC_DEFINES_SVH
`define XFC_DEFINES_SVH

// Register port offsets
`define XFC_OFS_EN_A      3'h0
`define XFC_OFS_EN_B      3'h1
`define XFC_OFS_EN_C      3'h2
`define XFC_OFS_EN_D      3'h3
`define XFC_OFS_EN_E      3'h4
`define XFC_OFS_SWVEC     3'h5
`define XFC_OFS_DONE_ACK  3'h6
`define XFC_OFS_STATUS    3'h7

// Field positions
`define XFC_SWVEC_ACT_BIT 7
`define XFC_MRA_SM        7:6
`define XFC_MRA_DM        5:4
`define XFC_MRA_MD        3:2
`define XFC_MRA_DTS       1
`define XFC_MRA_SZ        0
`define XFC_MRB_CHAIN     7
`define XFC_MRB_EVERY     6

// Transfer mode codes
`define XFC_MD_NORMAL     2'h0
`define XFC_MD_REPEAT     2'h1
`define XFC_MD_BLOCK      2'h2

// Reset values
`define XFC_EN_RST        40'h00_0000_0000
`define XFC_SWVEC_RST     7'h00

// Fixed addresses
`define XFC_RAM_BASE      24'hffec00
`define XFC_RAM_LAST      24'hffefff
`define XFC_RAM_PAGE      8'hff
`define XFC_VEC_BASE      24'h000400
`define XFC_DESC_BYTES    24'h00000c
`define XFC_WORD_BYTES    24'h000004
`define XFC_SW_SRC        6'h28

`endif

// *** rtl/xfc_pkg.sv ***
/*
  Types shared by the descriptor transfer controller: states and
  the single state record of the top module.
*/
package xfc_pkg;

  typedef enum logic [11:0] {
    XFC_IDLE = 12'h001,
    XFC_VEC  = 12'h002,
    XFC_RD0  = 12'h004,
    XFC_RD1  = 12'h008,
    XFC_RD2  = 12'h010,
    XFC_RD3  = 12'h020,
    XFC_DRD  = 12'h040,
    XFC_DWR  = 12'h080,
    XFC_WB0  = 12'h100,
    XFC_WB1  = 12'h200,
    XFC_WB2  = 12'h400,
    XFC_FIN  = 12'h800
  } xfc_state_t;

  typedef struct packed {
    xfc_state_t  st;
    logic [39:0] en;
    logic        software_activate;
    logic [6:0]  swvec;
    logic        sw_pend;
    logic        sw_done;
    logic [5:0]  src_id;
    logic [23:0] daddr;
    logic [7:0]  mode_word_first;
    logic [7:0]  mode_word_second;
    logic [23:0] source_pointer;
    logic [23:0] destination_pointer;
    logic [15:0] count_word_first;
    logic [15:0] count_word_second;
    logic [15:0] data;
    logic        last_end;
    logic [7:0]  rdata;
  } xfc_regs_t;

endpackage

// *** rtl/xfc_step.sv ***
/*
  Pointer stepper: next pointer after one unit, and the same pointer
  wound back over a whole repeat or block area. Pure combinational.
*/
`timescale 1ns/1ns
module xfc_step (
  input  wire logic [23:0] ptr,
  input  wire logic [1:0]  step_mode,
  input  wire logic        unit_size,
  input  wire logic [7:0]  area_len,
  output logic      [23:0] nxt,
  output logic      [23:0] rew
);
  logic [23:0] unit;
  logic [23:0] span;

  assign unit = unit_size ? 24'h000002 : 24'h000001;
  // Zero length stands for a full 256-unit area
  assign span = {15'h0000, (area_len == 8'h00), area_len} << unit_size;

  always_comb begin
    nxt = ptr;
    rew = ptr;
    if (step_mode == 2'h2) begin
      nxt = ptr + unit;
      rew = nxt - span;
    end else if (step_mode == 2'h3) begin
      nxt = ptr - unit;
      rew = nxt + span;
    end
  end
endmodule // xfc_step

// *** rtl/xfc_prio.sv ***
/*
  Fixed-priority picker: the lowest set index wins.
  Assumes the request vector is stable for the cycle it is read.
*/
`timescale 1ns/1ns
module xfc_prio #(
  parameter int N = 40
) (
  input  wire logic [N-1:0] req,
  output logic              found,
  output logic [5:0]        idx
);
  always_comb begin
    found = 1'b0;
    idx   = 6'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = 6'(i);
      end
    end
  end
endmodule // xfc_prio

// *** rtl/xfc_ctrl.sv ***
/*
  Descriptor transfer controller: activation, descriptor load and
  store over a 32-bit RAM path, unit moves over the internal bus.
  Assumes RAM read data one cycle after RAM_RE, and a bus that holds
  off with BUS_ACK low and returns read data beside BUS_ACK.
*/
`timescale 1ns/1ns
`include "xfc_defines.svh"

module xfc_ctrl (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [2:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic [39:0] SRC_REQ,
  output logic      [39:0] INT_PASS,
  output logic      [39:0] SRC_CLR,
  output logic             XFER_IRQ,
  output logic      [5:0]  XFER_IRQ_SRC,
  output logic             SW_DONE_IRQ,
  output logic             BUSY,
  output logic      [23:0] RAM_ADDR,
  output logic             RAM_RE,
  output logic             RAM_WE,
  output logic      [31:0] RAM_WDATA,
  input  wire logic [31:0] RAM_RDATA,
  output logic             BUS_REQ,
  output logic             BUS_WE,
  output logic             BUS_WORD,
  output logic      [23:0] BUS_ADDR,
  output logic      [15:0] BUS_WDATA,
  input  wire logic [15:0] BUS_RDATA,
  input  wire logic        BUS_ACK
);
  xfc_pkg::xfc_regs_t r_reg;
  xfc_pkg::xfc_regs_t r_next;

  logic        pick_found;
  logic [5:0]  pick_idx;
  logic [23:0] sar_nxt;
  logic [23:0] sar_rew;
  logic [23:0] dar_nxt;
  logic [23:0] dar_rew;
  logic [6:0]  vec_num;
  logic        irq_now;
  logic        is_sw;

  // Vector number of each hardware source; index is reg*8 + (7 - bit)
  function automatic logic [6:0] src_vec(input logic [5:0] i);
    logic [6:0] v;
    v = 7'h00;
    unique case (i)
      6'd0:    v = 7'd16;
      6'd1:    v = 7'd17;
      6'd2:    v = 7'd18;
      6'd3:    v = 7'd19;
      6'd4:    v = 7'd28;
      6'd9:    v = 7'd76;
      6'd10:   v = 7'd94;
      6'd19:   v = 7'd29;
      6'd21:   v = 7'd81;
      6'd22:   v = 7'd82;
      6'd23:   v = 7'd85;
      6'd24:   v = 7'd86;
      6'd27:   v = 7'd78;
      6'd28:   v = 7'd98;
      6'd36:   v = 7'd104;
      6'd37:   v = 7'd105;
      6'd38:   v = 7'd106;
      6'd39:   v = 7'd107;
      default: v = 7'h00;
    endcase
    return v;
  endfunction

  xfc_prio #(
    .N (40)
  ) u_prio (
    .req   (SRC_REQ & r_reg.en),
    .found (pick_found),
    .idx   (pick_idx)
  );

  xfc_step u_src_step (
    .ptr       (r_reg.source_pointer),
    .step_mode (r_reg.mode_word_first[`XFC_MRA_SM]),
    .unit_size (r_reg.mode_word_first[`XFC_MRA_SZ]),
    .area_len  (r_reg.count_word_first[15:8]),
    .nxt       (sar_nxt),
    .rew       (sar_rew)
  );

  xfc_step u_dst_step (
    .ptr       (r_reg.destination_pointer),
    .step_mode (r_reg.mode_word_first[`XFC_MRA_DM]),
    .unit_size (r_reg.mode_word_first[`XFC_MRA_SZ]),
    .area_len  (r_reg.count_word_first[15:8]),
    .nxt       (dar_nxt),
    .rew       (dar_rew)
  );

  assign is_sw   = (r_reg.src_id == `XFC_SW_SRC);
  // Interrupt every time or only at count end
  assign irq_now = r_reg.mode_word_second[`XFC_MRB_EVERY] | r_reg.last_end;
  assign vec_num = is_sw ? r_reg.swvec : src_vec(r_reg.src_id);

  // Enabled sources are withheld from the CPU
  assign INT_PASS     = SRC_REQ & ~r_reg.en;
  assign RDATA        = r_reg.rdata;
  assign SW_DONE_IRQ  = r_reg.sw_done;
  assign BUSY         = (r_reg.st != xfc_pkg::XFC_IDLE);
  assign XFER_IRQ_SRC = r_reg.src_id;

  always_comb begin
    r_next = r_reg;
    SRC_CLR   = 40'h00_0000_0000;
    XFER_IRQ  = 1'b0;
    RAM_ADDR  = r_reg.daddr;
    RAM_RE    = 1'b0;
    RAM_WE    = 1'b0;
    RAM_WDATA = 32'h0000_0000;
    BUS_REQ   = 1'b0;
    BUS_WE    = 1'b0;
    BUS_WORD  = 1'b0;
    BUS_ADDR  = r_reg.source_pointer;
    BUS_WDATA = r_reg.data;

    // Register port
    r_next.rdata = 8'h00;
    if (RD) begin
      unique case (ADDR)
        `XFC_OFS_EN_A, `XFC_OFS_EN_B, `XFC_OFS_EN_C, `XFC_OFS_EN_D, `XFC_OFS_EN_E: begin
          for (int b = 0; b < 8; b++) begin
            r_next.rdata[b] = r_reg.en[ADDR * 8 + 7 - b];
          end
        end
        `XFC_OFS_SWVEC:    r_next.rdata = {r_reg.software_activate, r_reg.swvec};
        `XFC_OFS_DONE_ACK: r_next.rdata = {7'h00, r_reg.sw_done};
        `XFC_OFS_STATUS:   r_next.rdata = {5'h00, BUSY, r_reg.sw_pend, r_reg.sw_done};
        default:           r_next.rdata = 8'h00;
      endcase
    end
    if (WR) begin
      unique case (ADDR)
        `XFC_OFS_EN_A, `XFC_OFS_EN_B, `XFC_OFS_EN_C, `XFC_OFS_EN_D, `XFC_OFS_EN_E: begin
          for (int b = 0; b < 8; b++) begin
            r_next.en[ADDR * 8 + 7 - b] = WDATA[b];
          end
        end
        `XFC_OFS_SWVEC: begin
          if (!r_reg.software_activate) begin
            r_next.swvec = WDATA[6:0];
          end
          if (WDATA[`XFC_SWVEC_ACT_BIT] && !r_reg.software_activate) begin
            r_next.software_activate   = 1'b1;
            r_next.sw_pend = 1'b1;
          end
        end
        `XFC_OFS_DONE_ACK: begin
          // Zero write after done interrupt releases activation
          if (!WDATA[0] && r_reg.sw_done) begin
            r_next.software_activate   = 1'b0;
            r_next.sw_done = 1'b0;
          end
        end
        default: ;
      endcase
    end

    unique case (r_reg.st)
      xfc_pkg::XFC_IDLE: begin
        // Software start ranks above every hardware source
        if (r_reg.sw_pend) begin
          r_next.sw_pend = WR && (ADDR == `XFC_OFS_SWVEC) && r_next.sw_pend && !r_reg.software_activate;
          r_next.src_id  = `XFC_SW_SRC;
          r_next.st      = xfc_pkg::XFC_VEC;
        end else if (pick_found) begin
          r_next.src_id = pick_idx;
          r_next.st     = xfc_pkg::XFC_VEC;
        end
      end
      xfc_pkg::XFC_VEC: begin
        BUS_REQ  = 1'b1;
        BUS_WORD = 1'b1;
        BUS_ADDR = `XFC_VEC_BASE + {16'h0000, vec_num, 1'b0};
        // Entry holds the low 16 bits of the descriptor address
        if (BUS_ACK) begin
          r_next.daddr = {`XFC_RAM_PAGE, BUS_RDATA};
          r_next.st    = xfc_pkg::XFC_RD0;
        end
      end
      xfc_pkg::XFC_RD0: begin
        RAM_RE    = 1'b1;
        r_next.st = xfc_pkg::XFC_RD1;
      end
      xfc_pkg::XFC_RD1: begin
        // Mode first with source, then mode second with destination
        r_next.mode_word_first = RAM_RDATA[31:24];
        r_next.source_pointer = RAM_RDATA[23:0];
        RAM_RE     = 1'b1;
        RAM_ADDR   = r_reg.daddr + `XFC_WORD_BYTES;
        r_next.st  = xfc_pkg::XFC_RD2;
      end
      xfc_pkg::XFC_RD2: begin
        r_next.mode_word_second = RAM_RDATA[31:24];
        r_next.destination_pointer = RAM_RDATA[23:0];
        RAM_RE     = 1'b1;
        RAM_ADDR   = r_reg.daddr + (`XFC_WORD_BYTES << 1);
        r_next.st  = xfc_pkg::XFC_RD3;
      end
      xfc_pkg::XFC_RD3: begin
        r_next.count_word_first = RAM_RDATA[31:16];
        r_next.count_word_second = RAM_RDATA[15:0];
        r_next.st  = xfc_pkg::XFC_DRD;
      end
      xfc_pkg::XFC_DRD: begin
        // Unit size picks byte or word access
        BUS_REQ  = 1'b1;
        BUS_WORD = r_reg.mode_word_first[`XFC_MRA_SZ];
        if (BUS_ACK) begin
          r_next.data = r_reg.mode_word_first[`XFC_MRA_SZ] ? BUS_RDATA : {8'h00, BUS_RDATA[7:0]};
          r_next.st   = xfc_pkg::XFC_DWR;
        end
      end
      xfc_pkg::XFC_DWR: begin
        BUS_REQ  = 1'b1;
        BUS_WE   = 1'b1;
        BUS_WORD = r_reg.mode_word_first[`XFC_MRA_SZ];
        BUS_ADDR = r_reg.destination_pointer;
        if (BUS_ACK) begin
          r_next.source_pointer      = sar_nxt;
          r_next.destination_pointer      = dar_nxt;
          r_next.last_end = 1'b0;
          r_next.st       = xfc_pkg::XFC_WB0;
          unique case (r_reg.mode_word_first[`XFC_MRA_MD])
            `XFC_MD_NORMAL: begin
              // Zero start wraps, giving the full 65536
              r_next.count_word_first      = r_reg.count_word_first - 16'h0001;
              r_next.last_end = (r_reg.count_word_first == 16'h0001);
            end
            `XFC_MD_REPEAT: begin
              // Low byte counts, high byte reloads
              r_next.count_word_first[7:0] = r_reg.count_word_first[7:0] - 8'h01;
              if (r_reg.count_word_first[7:0] == 8'h01) begin
                r_next.count_word_first[7:0] = r_reg.count_word_first[15:8];
                // Area pointer back to its start
                // Side chosen by the area bit
                if (r_reg.mode_word_first[`XFC_MRA_DTS]) begin
                  r_next.source_pointer = sar_rew;
                end else begin
                  r_next.destination_pointer = dar_rew;
                end
              end
            end
            `XFC_MD_BLOCK: begin
              r_next.count_word_first[7:0] = r_reg.count_word_first[7:0] - 8'h01;
              r_next.st       = xfc_pkg::XFC_DRD;
              if (r_reg.count_word_first[7:0] == 8'h01) begin
                r_next.count_word_first[7:0] = r_reg.count_word_first[15:8];
                // Block side restarts for the next block
                if (r_reg.mode_word_first[`XFC_MRA_DTS]) begin
                  r_next.source_pointer = sar_rew;
                end else begin
                  r_next.destination_pointer = dar_rew;
                end
                r_next.count_word_second      = r_reg.count_word_second - 16'h0001;
                r_next.last_end = (r_reg.count_word_second == 16'h0001);
                r_next.st       = xfc_pkg::XFC_WB0;
              end
            end
            default: ;
          endcase
        end
      end
      // Updated descriptor back to the same place
      xfc_pkg::XFC_WB0: begin
        RAM_WE    = 1'b1;
        RAM_WDATA = {r_reg.mode_word_first, r_reg.source_pointer};
        r_next.st = xfc_pkg::XFC_WB1;
      end
      xfc_pkg::XFC_WB1: begin
        RAM_WE    = 1'b1;
        RAM_ADDR  = r_reg.daddr + `XFC_WORD_BYTES;
        RAM_WDATA = {r_reg.mode_word_second, r_reg.destination_pointer};
        r_next.st = xfc_pkg::XFC_WB2;
      end
      xfc_pkg::XFC_WB2: begin
        RAM_WE    = 1'b1;
        RAM_ADDR  = r_reg.daddr + (`XFC_WORD_BYTES << 1);
        RAM_WDATA = {r_reg.count_word_first, r_reg.count_word_second};
        r_next.st = xfc_pkg::XFC_FIN;
        // Chained step takes no end action
        if (r_reg.mode_word_second[`XFC_MRB_CHAIN]) begin
          r_next.daddr = r_reg.daddr + `XFC_DESC_BYTES;
          r_next.st    = xfc_pkg::XFC_RD0;
        end
      end
      xfc_pkg::XFC_FIN: begin
        r_next.st = xfc_pkg::XFC_IDLE;
        if (is_sw) begin
          if (irq_now) begin
            r_next.sw_done = 1'b1;
          end else begin
            r_next.software_activate = 1'b0;
          end
        end else if (irq_now) begin
          // Enable dropped, CPU takes the interrupt
          // Enable cleared instead of the flag
          XFER_IRQ = 1'b1;
          r_next.en[r_reg.src_id] = 1'b0;
        end else begin
          SRC_CLR[r_reg.src_id] = 1'b1;
        end
      end
      default: r_next.st = xfc_pkg::XFC_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      r_reg       <= '0;
      r_reg.st    <= xfc_pkg::XFC_IDLE;
      r_reg.en    <= `XFC_EN_RST;
      r_reg.swvec <= `XFC_SWVEC_RST;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule // xfc_ctrl

// *** tb/xfc_ctrl_asserts.sv ***
/*
  Port checker of the transfer controller.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ns
module xfc_ctrl_asserts (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic [2:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic [39:0] SRC_CLR,
  input wire logic        XFER_IRQ,
  input wire logic        SW_DONE_IRQ,
  input wire logic        BUSY,
  input wire logic [23:0] RAM_ADDR,
  input wire logic        RAM_RE,
  input wire logic        RAM_WE,
  input wire logic        BUS_REQ,
  input wire logic        BUS_WE,
  input wire logic        BUS_WORD,
  input wire logic [23:0] BUS_ADDR,
  input wire logic        BUS_ACK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic [23:0] base_reg;
  // Base of last descriptor read, so a chain store is judged per link
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) base_reg <= 24'h000000;
    else if ($rose(RAM_RE)) base_reg <= RAM_ADDR;
  end
  sequence three_reads;
    RAM_RE [*3] ##1 !RAM_RE;
  endsequence
  sequence three_writes;
    RAM_WE [*3] ##1 !RAM_WE;
  endsequence
  a_ram_window:
    assert property ((RAM_RE || RAM_WE) |-> RAM_ADDR >= 24'hffec00
      && RAM_ADDR <= 24'hffefff && RAM_ADDR[1:0] == 2'h0) else $error("ram address out");
  a_desc_reads:
    assert property ($rose(RAM_RE) |-> three_reads) else $error("descriptor read count");
  a_read_step:
    assert property (RAM_RE && $past(RAM_RE) |-> RAM_ADDR == $past(RAM_ADDR) + 24'h000004)
      else $error("descriptor word order");
  a_store_place:
    assert property ($rose(RAM_WE) |-> RAM_ADDR == base_reg ##1 RAM_ADDR == base_reg + 24'h4)
      else $error("store back misplaced");
  a_store_len:
    assert property ($rose(RAM_WE) |-> three_writes) else $error("store back count");
  a_vector_fetch:
    assert property ($rose(BUSY) |-> ##[0:1] (BUS_REQ && !BUS_WE && BUS_WORD
      && BUS_ADDR[23:8] == 16'h0004 && !BUS_ADDR[0])) else $error("vector fetch");
  a_bus_hold:
    assert property (BUS_REQ && !BUS_ACK |=> BUS_REQ && $stable(BUS_ADDR)
      && $stable(BUS_WE) && $stable(BUS_WORD)) else $error("bus request dropped");
  a_irq_finish:
    assert property (XFER_IRQ |-> BUSY && SRC_CLR == 40'h0 ##1 !BUSY && !XFER_IRQ)
      else $error("irq pulse");
  a_clear_one:
    assert property (SRC_CLR != 40'h0 |-> $onehot(SRC_CLR) && BUSY ##1 SRC_CLR == 40'h0)
      else $error("flag clear pulse");
  a_done_hold:
    assert property (SW_DONE_IRQ && !(WR && ADDR == 3'h6 && !WDATA[0]) |=> SW_DONE_IRQ)
      else $error("done irq lost");
endmodule // xfc_ctrl_asserts

bind xfc_ctrl xfc_ctrl_asserts u_xfc_ctrl_asserts (
  .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .SRC_CLR(SRC_CLR),
  .XFER_IRQ(XFER_IRQ), .SW_DONE_IRQ(SW_DONE_IRQ), .BUSY(BUSY), .RAM_ADDR(RAM_ADDR),
  .RAM_RE(RAM_RE), .RAM_WE(RAM_WE), .BUS_REQ(BUS_REQ), .BUS_WE(BUS_WE),
  .BUS_WORD(BUS_WORD), .BUS_ADDR(BUS_ADDR), .BUS_ACK(BUS_ACK)
);

// *** tb/xfc_mem_model.sv ***
/*
  Far side: descriptor RAM and the internal bus with memory behind it.
  Assumes the bench fills both arrays before each start.
*/
`timescale 1ns/1ns
module xfc_mem_model (
  input  wire logic        CLK,
  input  wire logic [23:0] RAM_ADDR,
  input  wire logic        RAM_RE,
  input  wire logic        RAM_WE,
  input  wire logic [31:0] RAM_WDATA,
  output logic      [31:0] RAM_RDATA,
  input  wire logic        BUS_REQ,
  input  wire logic        BUS_WE,
  input  wire logic        BUS_WORD,
  input  wire logic [23:0] BUS_ADDR,
  input  wire logic [15:0] BUS_WDATA,
  output logic      [15:0] BUS_RDATA,
  output logic             BUS_ACK
);
  logic [7:0]  mem [logic [23:0]];
  logic [31:0] ram [logic [23:0]];
  logic [15:0] noise_reg = 16'h3c96;
  int          wait_cyc = 0;
  int          cnt = 0;
  always @(posedge CLK) begin
    noise_reg <= {noise_reg[14:0], ~noise_reg[15]};
    // Idle read port shows noise, so a late sample cannot pass by luck
    RAM_RDATA <= RAM_RE ? ram[RAM_ADDR] : {noise_reg, ~noise_reg};
    if (RAM_WE) ram[RAM_ADDR] = RAM_WDATA;
    cnt <= (BUS_REQ && !BUS_ACK) ? cnt + 1 : 0;
    if (BUS_ACK && BUS_WE) begin
      mem[BUS_ADDR] = BUS_WORD ? BUS_WDATA[15:8] : BUS_WDATA[7:0];
      if (BUS_WORD) mem[BUS_ADDR + 24'h1] = BUS_WDATA[7:0];
    end
  end
  // Slow answers on request, noise outside the acknowledged cycle
  assign BUS_ACK = BUS_REQ && cnt >= wait_cyc;
  always @* begin
    if (BUS_ACK && !BUS_WE && BUS_WORD) BUS_RDATA = {mem[BUS_ADDR], mem[BUS_ADDR + 24'h1]};
    else if (BUS_ACK && !BUS_WE) BUS_RDATA = {8'h00, mem[BUS_ADDR]};
    else BUS_RDATA = noise_reg;
  end
endmodule // xfc_mem_model

// *** tb/xfc_ctrl_tb_top.sv ***
/*
  Bench of the transfer controller: register tasks and descriptor runs.
  Assumes the memory model answers the bus and RAM sides.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module xfc_ctrl_tb_top;
  logic        CLK, NRST, WR, RD, XFER_IRQ, SW_DONE_IRQ, BUSY, RAM_RE, RAM_WE;
  logic        BUS_REQ, BUS_WE, BUS_WORD, BUS_ACK;
  logic [2:0]  ADDR;
  logic [5:0]  XFER_IRQ_SRC, first_src;
  logic [7:0]  WDATA, RDATA;
  logic [15:0] BUS_WDATA, BUS_RDATA;
  logic [23:0] RAM_ADDR, BUS_ADDR;
  logic [31:0] RAM_WDATA, RAM_RDATA;
  logic [39:0] SRC_REQ, INT_PASS, SRC_CLR;
  logic [39:0] src_lvl, clr_seen;
  int          miscompares = 0, n_tests = 0, cyc = 0, irq_n = 0, clr_n = 0;
  xfc_ctrl u_xfc_ctrl (
    .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SRC_REQ(SRC_REQ), .INT_PASS(INT_PASS), .SRC_CLR(SRC_CLR), .XFER_IRQ(XFER_IRQ),
    .XFER_IRQ_SRC(XFER_IRQ_SRC), .SW_DONE_IRQ(SW_DONE_IRQ), .BUSY(BUSY),
    .RAM_ADDR(RAM_ADDR), .RAM_RE(RAM_RE), .RAM_WE(RAM_WE), .RAM_WDATA(RAM_WDATA),
    .RAM_RDATA(RAM_RDATA), .BUS_REQ(BUS_REQ), .BUS_WE(BUS_WE), .BUS_WORD(BUS_WORD),
    .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA), .BUS_ACK(BUS_ACK)
  );
  xfc_mem_model u_mem (
    .CLK(CLK), .RAM_ADDR(RAM_ADDR), .RAM_RE(RAM_RE), .RAM_WE(RAM_WE),
    .RAM_WDATA(RAM_WDATA), .RAM_RDATA(RAM_RDATA), .BUS_REQ(BUS_REQ), .BUS_WE(BUS_WE),
    .BUS_WORD(BUS_WORD), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
    .BUS_RDATA(BUS_RDATA), .BUS_ACK(BUS_ACK)
  );
  initial CLK = 1'b0;
  always #5 CLK = ~CLK;
  // Flag stands while its source level is up and no clear was seen
  assign SRC_REQ = src_lvl & ~clr_seen;
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Stands in for the interrupt controller: a cleared flag drops
  always @(posedge CLK) begin
    cyc++;
    // A cleared flag stays low until its source level drops and rises again
    clr_seen <= (clr_seen | SRC_CLR) & src_lvl;
    if ((|SRC_CLR) === 1'b1) begin
      clr_n++;
    end
    if (XFER_IRQ === 1'b1) begin
      if (irq_n == 0) first_src = XFER_IRQ_SRC;
      irq_n++;
    end
    if (cyc > 5000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e, input string nm);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    `CHK(nm, e, RDATA)
    @(posedge CLK);
  endtask
  function automatic logic [23:0] da(input int k, input int i);
    return 24'hffec00 + 24'(12 * k + 4 * i);
  endfunction
  task automatic ld(input int k, input logic [7:0] ma, input logic [23:0] s,
                    input logic [7:0] mb, input logic [23:0] d, input logic [31:0] c);
    u_mem.ram[da(k, 0)] = {ma, s};
    u_mem.ram[da(k, 1)] = {mb, d};
    u_mem.ram[da(k, 2)] = c;
  endtask
  task automatic cw(input int k, input int i, input logic [31:0] e, input string nm);
    `CHK(nm, e, u_mem.ram[da(k, i)])
  endtask
  // Bounded wait for the controller to go idle
  task automatic idle();
    for (int i = 0; i < 600 && (i < 3 || BUSY !== 1'b0); i++) @(posedge CLK);
  endtask
  initial begin
    NRST <= 1'b0;
    ADDR <= 3'h0;
    WDATA <= 8'h00;
    WR <= 1'b0;
    RD <= 1'b0;
    src_lvl <= 40'h0;
    for (int a = 0; a < 256; a += 2) begin
      u_mem.mem[24'h000400 + 24'(a)] = 8'hec;
      u_mem.mem[24'h000401 + 24'(a)] = 8'h00;
    end
    repeat (6) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    for (int a = 0; a < 8; a++) rc(3'(a), 8'h00, "reset");
    u_mem.mem[24'h001000] = 8'ha5;
    u_mem.mem[24'h001001] = 8'h3c;
    ld(0, 8'ha0, 24'h001000, 8'h00, 24'h002000, 32'h0002_0000);
    wr(3'h5, 8'h90);
    idle();
    `CHK("byte", 8'ha5, u_mem.mem[24'h002000])
    cw(0, 0, 32'ha000_1001, "src up");
    cw(0, 1, 32'h0000_2001, "dst up");
    cw(0, 2, 32'h0001_0000, "count");
    rc(3'h5, 8'h10, "sw cleared");
    wr(3'h5, 8'h90);
    idle();
    cw(0, 2, 32'h0000_0000, "count end");
    `CHK("sw done", 1'b1, SW_DONE_IRQ)
    wr(3'h5, 8'h22);
    rc(3'h5, 8'h90, "locked");
    wr(3'h6, 8'h00);
    rc(3'h5, 8'h10, "ack");
    wr(3'h5, 8'h05);
    rc(3'h7, 8'h00, "no start");
    rc(3'h5, 8'h05, "vector");
    u_mem.mem[24'h001100] = 8'h12;
    u_mem.mem[24'h001101] = 8'h34;
    ld(0, 8'he1, 24'h001100, 8'h40, 24'h002100, 32'h0003_0000);
    wr(3'h0, 8'h80);
    src_lvl <= 40'h1;
    @(posedge CLK);
    #1;
    `CHK("routed", 1'b0, INT_PASS[0])
    idle();
    `CHK("word", 16'h1234, {u_mem.mem[24'h002100], u_mem.mem[24'h002101]})
    cw(0, 0, 32'he100_10fe, "src down");
    cw(0, 1, 32'h4000_2102, "dst word");
    `CHK("irq", 1, irq_n)
    rc(3'h0, 8'h00, "en cleared");
    `CHK("to cpu", 1'b1, INT_PASS[0])
    src_lvl <= 40'h0;
    ld(0, 8'ha0, 24'h001000, 8'h00, 24'h002200, 32'h0002_0000);
    wr(3'h0, 8'h80);
    irq_n = 0;
    src_lvl <= 40'h1;
    idle();
    `CHK("flag clr", 1, clr_n)
    `CHK("no irq", 0, irq_n)
    src_lvl <= 40'h0;
    rc(3'h0, 8'h80, "en kept");
    u_mem.wait_cyc = 2;
    ld(0, 8'ha8, 24'h001000, 8'h00, 24'h002300, 32'h0202_0002);
    wr(3'h5, 8'h90);
    idle();
    `CHK("block", 16'ha53c, {u_mem.mem[24'h002300], u_mem.mem[24'h002301]})
    cw(0, 0, 32'ha800_1002, "src on");
    cw(0, 1, 32'h0000_2300, "dst back");
    cw(0, 2, 32'h0202_0001, "blocks");
    ld(0, 8'ha6, 24'h001100, 8'h00, 24'h002400, 32'h0101_0000);
    wr(3'h5, 8'h90);
    idle();
    cw(0, 0, 32'ha600_1100, "src back");
    cw(0, 1, 32'h0000_2401, "dst on");
    cw(0, 2, 32'h0101_0000, "reload");
    rc(3'h5, 8'h10, "no end");
    u_mem.wait_cyc = 0;
    ld(0, 8'h00, 24'h001000, 8'h80, 24'h002500, 32'h0001_0000);
    ld(1, 8'h00, 24'h001100, 8'h00, 24'h002600, 32'h0005_0000);
    wr(3'h5, 8'h90);
    idle();
    `CHK("link", 16'ha512, {u_mem.mem[24'h002500], u_mem.mem[24'h002600]})
    cw(1, 2, 32'h0004_0000, "link count");
    `CHK("no done", 1'b0, SW_DONE_IRQ)
    rc(3'h5, 8'h10, "chain");
    ld(0, 8'h30, 24'h001000, 8'h40, 24'h002700, 32'h0009_0000);
    wr(3'h0, 8'hc0);
    irq_n = 0;
    src_lvl <= 40'h3;
    for (int i = 0; i < 200 && irq_n < 2; i++) @(posedge CLK);
    idle();
    `CHK("first", 6'h00, first_src)
    `CHK("two irq", 2, irq_n)
    cw(0, 1, 32'h4000_26fe, "dst down");
    cw(0, 2, 32'h0007_0000, "two moves");
    rc(3'h0, 8'h00, "both");
    end_sim();
  end
endmodule // xfc_ctrl_tb_top
